// File: hdl/itr_pkg.sv
// constants, opcodes and state layout of the interrupt/timer transfer block
package itr_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_ACC = 8'h04;
   localparam logic [7:0] ADDR_AUX = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;

   // status register bit positions
   localparam int STAT_IRQ_EN_BIT = 0;
   localparam int STAT_EXT0_REQ_BIT = 1;
   localparam int STAT_SKIP_BIT = 2;
   localparam int STAT_INT_PIN_BIT = 3;

   // field positions inside the control registers
   localparam int EXT0_EN_BIT = 0;
   localparam int PIN_POL_BIT = 2;

   // top bit index of the opcode field in the command word
   localparam int OP_MSB = 4;

   // reset values
   localparam logic [3:0] NIB_RST = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef enum logic [4:0] {
      OP_NO_OPERATION = 5'h00,
      OP_IRQ_DISABLE = 5'h01,
      OP_IRQ_ENABLE = 5'h02,
      OP_TEST_EXT0 = 5'h03,
      OP_TEST_PIN = 5'h04,
      OP_RD_IRQ_FIRST = 5'h05,
      OP_WR_IRQ_FIRST = 5'h06,
      OP_RD_IRQ_SECOND = 5'h07,
      OP_WR_IRQ_SECOND = 5'h08,
      OP_RD_PIN_IRQ = 5'h09,
      OP_WR_PIN_IRQ = 5'h0A,
      OP_WR_PSC_CTRL = 5'h0B,
      OP_RD_TMR_FIRST = 5'h0C,
      OP_WR_TMR_FIRST = 5'h0D,
      OP_RD_TMR_SECOND = 5'h0E,
      OP_WR_TMR_SECOND = 5'h0F,
      OP_RD_TMR_FIFTH = 5'h10,
      OP_WR_TMR_FIFTH = 5'h11,
      OP_RD_TMR_SIXTH = 5'h12,
      OP_WR_TMR_SIXTH = 5'h13,
      OP_RD_PSC = 5'h14,
      OP_WR_PSC = 5'h15,
      OP_RD_T1 = 5'h16,
      OP_WR_T1 = 5'h17,
      OP_WR_T1_HIGH = 5'h18
   } itr_op_t;

   typedef struct packed {
      logic [3:0] acc;
      logic [3:0] aux;
      logic [3:0] irq_control_first;
      logic [3:0] irq_control_second;
      logic [3:0] pin_irq_control;
      logic [3:0] prescaler_control;
      logic [3:0] timer_control_first;
      logic [3:0] timer_control_second;
      logic [3:0] timer_control_fifth;
      logic [3:0] timer_control_sixth;
      logic [7:0] psc_count;
      logic [7:0] prescaler_reload;
      logic [7:0] t1_count;
      logic [7:0] timer1_reload_low;
      logic [7:0] timer1_reload_high;
      logic irq_en;
      logic ext0_req;
      logic skip;
      logic [1:0] int_sync;
      logic [1:0] ext0_sync;
      logic ext0_prev;
      logic wr_pend;
      logic [7:0] wr_off;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } itr_state_t;

   localparam itr_state_t STATE_RST = '{hreadyout: 1'b1, default: '0};

endpackage

// File: hdl/itr_core.sv
// interrupt control and timer transfer execution unit with bus slave
`timescale 1ns/1ps

module itr_core (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic int_pin,
   input wire logic ext0_pin,
   output logic master_irq_enable_flag,
   output logic ext0_request_flag,
   output logic skip_pending
);

   itr_pkg::itr_state_t q;
   itr_pkg::itr_state_t d;
   logic cmd_wr;
   logic exec_now;
   logic ext0_rise;
   logic addr_rd;
   logic addr_wr;
   itr_pkg::itr_op_t op_now;

   // word-aligned offset hit within the low 256 bytes
   function automatic logic in_map(input logic [31:0] a);
      in_map = (a[31:8] == 24'h00_0000) && (a[1:0] == 2'b00);
   endfunction

   // readback of the bus-visible registers from a given state
   function automatic logic [31:0] read_word(
      input logic [7:0] off,
      input itr_pkg::itr_state_t s
   );
      logic [31:0] w;
      w = itr_pkg::WORD_ZERO;
      unique case (off)
         itr_pkg::ADDR_ACC: w[3:0] = s.acc;
         itr_pkg::ADDR_AUX: w[3:0] = s.aux;
         itr_pkg::ADDR_STATUS:
         begin
            w[itr_pkg::STAT_IRQ_EN_BIT] = s.irq_en;
            w[itr_pkg::STAT_EXT0_REQ_BIT] = s.ext0_req;
            w[itr_pkg::STAT_SKIP_BIT] = s.skip;
            w[itr_pkg::STAT_INT_PIN_BIT] = s.int_sync[1];
         end
         default: w = itr_pkg::WORD_ZERO;
      endcase
      read_word = w;
   endfunction

   assign cmd_wr = q.wr_pend && (q.wr_off == itr_pkg::ADDR_CMD);
   assign exec_now = cmd_wr && !q.skip;
   assign op_now = itr_pkg::itr_op_t'(hwdata[itr_pkg::OP_MSB:0]);
   assign ext0_rise = q.ext0_sync[1] && !q.ext0_prev;
   assign addr_wr = hsel && hready && htrans[1] && hwrite;
   assign addr_rd = hsel && hready && htrans[1] && !hwrite;

   always_comb
   begin
      d = q;
      d.int_sync = {q.int_sync[0], int_pin};
      d.ext0_sync = {q.ext0_sync[0], ext0_pin};
      d.ext0_prev = q.ext0_sync[1];
      d.hreadyout = 1'b1;
      d.hresp = 1'b0;

      // data phase of a write
      if (q.wr_pend)
      begin
         unique case (q.wr_off)
            itr_pkg::ADDR_ACC: d.acc = hwdata[3:0];
            itr_pkg::ADDR_AUX: d.aux = hwdata[3:0];
            default: d.acc = q.acc;
         endcase
      end

      // instruction discarded, only the skip mark drops
      if (cmd_wr && q.skip)
      begin
         d.skip = 1'b0;
      end

      if (exec_now)
      begin
         d.skip = 1'b0;
         unique case (op_now)
            itr_pkg::OP_IRQ_DISABLE: d.irq_en = 1'b0;
            itr_pkg::OP_IRQ_ENABLE: d.irq_en = 1'b1;
            itr_pkg::OP_TEST_EXT0:
            begin
               // enabled source: acts as no_operation
               if (!q.irq_control_first[itr_pkg::EXT0_EN_BIT]
                   && q.ext0_req)
               begin
                  d.ext0_req = 1'b0;
                  d.skip = 1'b1;
               end
            end
            itr_pkg::OP_TEST_PIN:
            begin
               // skip when synced pin equals polarity
               d.skip = (q.int_sync[1]
                  == q.pin_irq_control[itr_pkg::PIN_POL_BIT]);
            end
            itr_pkg::OP_RD_IRQ_FIRST:
               d.acc = q.irq_control_first;
            itr_pkg::OP_WR_IRQ_FIRST:
               d.irq_control_first = q.acc;
            itr_pkg::OP_RD_IRQ_SECOND:
               d.acc = q.irq_control_second;
            itr_pkg::OP_WR_IRQ_SECOND:
               d.irq_control_second = q.acc;
            itr_pkg::OP_RD_PIN_IRQ:
               d.acc = q.pin_irq_control;
            itr_pkg::OP_WR_PIN_IRQ:
               d.pin_irq_control = q.acc;
            itr_pkg::OP_WR_PSC_CTRL:
               d.prescaler_control = q.acc;
            itr_pkg::OP_RD_TMR_FIRST:
               d.acc = q.timer_control_first;
            itr_pkg::OP_WR_TMR_FIRST:
               d.timer_control_first = q.acc;
            itr_pkg::OP_RD_TMR_SECOND:
               d.acc = q.timer_control_second;
            itr_pkg::OP_WR_TMR_SECOND:
               d.timer_control_second = q.acc;
            itr_pkg::OP_RD_TMR_FIFTH:
               d.acc = q.timer_control_fifth;
            itr_pkg::OP_WR_TMR_FIFTH:
               d.timer_control_fifth = q.acc;
            itr_pkg::OP_RD_TMR_SIXTH:
               d.acc = q.timer_control_sixth;
            itr_pkg::OP_WR_TMR_SIXTH:
               d.timer_control_sixth = q.acc;
            itr_pkg::OP_RD_PSC:
            begin
               d.aux = q.psc_count[7:4];
               d.acc = q.psc_count[3:0];
            end
            itr_pkg::OP_WR_PSC:
            begin
               d.psc_count = {q.aux, q.acc};
               d.prescaler_reload = {q.aux, q.acc};
            end
            itr_pkg::OP_RD_T1:
            begin
               d.aux = q.t1_count[7:4];
               d.acc = q.t1_count[3:0];
            end
            itr_pkg::OP_WR_T1:
            begin
               d.t1_count = {q.aux, q.acc};
               d.timer1_reload_low = {q.aux, q.acc};
            end
            itr_pkg::OP_WR_T1_HIGH:
               d.timer1_reload_high = {q.aux, q.acc};
            itr_pkg::OP_NO_OPERATION: d.skip = 1'b0;
            default: d.skip = 1'b0;
         endcase
      end

      // a request edge wins over a clear in the same cycle
      if (ext0_rise)
      begin
         d.ext0_req = 1'b1;
      end

      // address phase; readback reflects a write landing this cycle
      d.wr_pend = addr_wr && in_map(haddr);
      d.wr_off = haddr[7:0];
      if (addr_rd && in_map(haddr))
      begin
         d.hrdata = read_word(haddr[7:0], d);
         if (haddr[7:0] == itr_pkg::ADDR_STATUS)
         begin
            // pin level from the second synchroniser stage only
            d.hrdata[itr_pkg::STAT_INT_PIN_BIT] = q.int_sync[1];
         end
      end
      else
      begin
         d.hrdata = itr_pkg::WORD_ZERO;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= itr_pkg::STATE_RST;
      end
      else
      begin
         q <= d;
      end
   end

   assign hrdata = q.hrdata;
   assign hreadyout = q.hreadyout;
   assign hresp = q.hresp;
   assign master_irq_enable_flag = q.irq_en;
   assign ext0_request_flag = q.ext0_req;
   assign skip_pending = q.skip;

   property p_irq_disable;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_IRQ_DISABLE |=> !q.irq_en;
   endproperty
   a_irq_disable: assert property (p_irq_disable)
      else $error("interrupt enable not cleared");

   property p_irq_enable;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_IRQ_ENABLE
         |=> q.irq_en;
   endproperty
   a_irq_enable: assert property (p_irq_enable)
      else $error("interrupt enable not set");

   property p_ext0_take;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_TEST_EXT0
         && !q.irq_control_first[itr_pkg::EXT0_EN_BIT]
         && q.ext0_req && !ext0_rise
         |=> q.skip && !q.ext0_req;
   endproperty
   a_ext0_take: assert property (p_ext0_take)
      else $error("ext0 test did not clear and skip");

   property p_ext0_idle;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_TEST_EXT0
         && q.irq_control_first[itr_pkg::EXT0_EN_BIT]
         |=> !q.skip && (q.ext0_req || !$past(q.ext0_req));
   endproperty
   a_ext0_idle: assert property (p_ext0_idle)
      else $error("ext0 test acted while source enabled");

   property p_pin_low;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_TEST_PIN
         && !q.pin_irq_control[itr_pkg::PIN_POL_BIT]
         |=> q.skip == !$past(q.int_sync[1]);
   endproperty
   a_pin_low: assert property (p_pin_low)
      else $error("pin test wrong for low polarity");

   property p_pin_high;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_TEST_PIN
         && q.pin_irq_control[itr_pkg::PIN_POL_BIT]
         |=> q.skip == $past(q.int_sync[1]);
   endproperty
   a_pin_high: assert property (p_pin_high)
      else $error("pin test wrong for high polarity");

   property p_irq_first_move;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_WR_IRQ_FIRST
         |=> q.irq_control_first == $past(q.acc);
   endproperty
   a_irq_first_move: assert property (p_irq_first_move)
      else $error("first interrupt control not loaded");

   property p_irq_second_read;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_RD_IRQ_SECOND
         |=> q.acc == $past(q.irq_control_second);
   endproperty
   a_irq_second_read: assert property (p_irq_second_read)
      else $error("acc not loaded from second interrupt control");

   property p_pin_ctrl_move;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_WR_PIN_IRQ
         |=> q.pin_irq_control == $past(q.acc);
   endproperty
   a_pin_ctrl_move: assert property (p_pin_ctrl_move)
      else $error("pin interrupt control not loaded");

   property p_psc_ctrl_move;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_WR_PSC_CTRL
         |=> q.prescaler_control == $past(q.acc) && $stable(q.acc);
   endproperty
   a_psc_ctrl_move: assert property (p_psc_ctrl_move)
      else $error("prescaler control not loaded");

   property p_tmr_second_move;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_WR_TMR_SECOND
         |=> q.timer_control_second == $past(q.acc);
   endproperty
   a_tmr_second_move: assert property (p_tmr_second_move)
      else $error("second timer control not loaded");

   property p_tmr_sixth_read;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_RD_TMR_SIXTH
         |=> q.acc == $past(q.timer_control_sixth);
   endproperty
   a_tmr_sixth_read: assert property (p_tmr_sixth_read)
      else $error("acc not loaded from sixth timer control");

   property p_psc_read;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_RD_PSC
         |=> {q.aux, q.acc} == $past(q.psc_count);
   endproperty
   a_psc_read: assert property (p_psc_read)
      else $error("prescaler read split wrong");

   property p_psc_write;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_WR_PSC
         |=> q.psc_count == {$past(q.aux), $past(q.acc)}
            && q.prescaler_reload == q.psc_count;
   endproperty
   a_psc_write: assert property (p_psc_write)
      else $error("prescaler write did not load both");

   property p_t1_read;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_RD_T1
         |=> q.aux == $past(q.t1_count[7:4])
            && q.acc == $past(q.t1_count[3:0]);
   endproperty
   a_t1_read: assert property (p_t1_read)
      else $error("timer 1 read split wrong");

   property p_t1_write;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_WR_T1
         |=> q.t1_count == {$past(q.aux), $past(q.acc)}
            && q.timer1_reload_low == q.t1_count;
   endproperty
   a_t1_write: assert property (p_t1_write)
      else $error("timer 1 write did not load both");

   property p_t1_high;
      @(posedge hclk) disable iff (!hresetn)
      exec_now && op_now == itr_pkg::OP_WR_T1_HIGH
         |=> q.timer1_reload_high == {$past(q.aux), $past(q.acc)}
            && $stable(q.t1_count);
   endproperty
   a_t1_high: assert property (p_t1_high)
      else $error("high reload write disturbed count");

   property p_discard;
      @(posedge hclk) disable iff (!hresetn)
      cmd_wr && q.skip
         |=> !q.skip && $stable(q.acc) && $stable(q.aux)
            && $stable(q.irq_en) && $stable(q.t1_count)
            && $stable(q.psc_count) && $stable(q.irq_control_first);
   endproperty
   a_discard: assert property (p_discard)
      else $error("skipped instruction changed state");

endmodule

// File: sim/itr_pin_model.sv
// far-side model: external interrupt pin and external 0 request source
`timescale 1ns/1ps

module itr_pin_model (
   input wire logic hclk,
   input wire logic int_lvl,
   input wire logic ext0_fire,
   output logic int_pin,
   output logic ext0_pin
);
   logic pin_q = 1'b0;
   logic [2:0] pulse_q = 3'h0;

   // pins change only just after a clock edge
   always_ff @(posedge hclk)
   begin
      pin_q <= int_lvl;
      if (ext0_fire)
         pulse_q <= 3'h4;
      else if (pulse_q != 3'h0)
         pulse_q <= pulse_q - 3'h1;
   end

   // pulse outlasts the two-flop synchroniser so the edge is seen
   assign int_pin = pin_q;
   assign ext0_pin = (pulse_q != 3'h0);
endmodule

// File: sim/tb.sv
// self-checking testbench for the interrupt/timer transfer block
`timescale 1ns/1ps

module tb;
   logic hclk, hresetn, hsel, hwrite, hready, int_lvl, ext0_fire;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, int_pin, ext0_pin;
   logic irq_o, ext0_o, skip_o, rdy_s, resp_s;
   logic [31:0] rdat_s;
   logic [2:0] flag_s;
   int n_errors = 0;
   int samples_checked = 0;

   assign hready = hreadyout;

   itr_core itr_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .int_pin(int_pin),
      .ext0_pin(ext0_pin), .master_irq_enable_flag(irq_o),
      .ext0_request_flag(ext0_o), .skip_pending(skip_o));

   // outputs taken mid-cycle, so they hold across the next rising edge
   always @(negedge hclk)
   begin
      rdy_s <= hreadyout;
      resp_s <= hresp;
      rdat_s <= hrdata;
      flag_s <= {skip_o, ext0_o, irq_o};
   end

   itr_pin_model itr_pin_model_i (.hclk(hclk), .int_lvl(int_lvl),
      .ext0_fire(ext0_fire), .int_pin(int_pin), .ext0_pin(ext0_pin));

   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   task results;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task wait_rdy;
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (rdy_s !== 1'b1 && k < 100);
      if (rdy_s !== 1'b1)
      begin
         n_errors++;
         results;
      end
   endtask

   // one single word transfer; read data lands in rd
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      rd = rdat_s;
      chk({31'h0, resp_s}, 32'h0000_0000);
   endtask

   task cmd(input logic [4:0] op);
      bus(1'b1, itr_pkg::ADDR_CMD, {27'h000_0000, op});
   endtask

   task set_acc(input logic [3:0] v);
      bus(1'b1, itr_pkg::ADDR_ACC, {28'h000_0000, v});
   endtask

   task set_aux(input logic [3:0] v);
      bus(1'b1, itr_pkg::ADDR_AUX, {28'h000_0000, v});
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // status polled until bit b shows v, bounded
   task poll(input int b, input logic v);
      int k;
      k = 0;
      do
      begin
         bus(1'b0, itr_pkg::ADDR_STATUS, 32'h0000_0000);
         k++;
      end
      while (rd[b] !== v && k < 20);
      chk({31'h0, rd[b]}, {31'h0, v});
   endtask

   task t_irq;
      cmd(itr_pkg::OP_IRQ_ENABLE);
      rd_chk(itr_pkg::ADDR_STATUS, 32'h0000_0001);
      chk({29'h0, flag_s}, 32'h0000_0001);
      cmd(itr_pkg::OP_IRQ_DISABLE);
      rd_chk(itr_pkg::ADDR_STATUS, 32'h0000_0000);
      chk({29'h0, flag_s}, 32'h0000_0000);
   endtask

   // read opcode is the base, write opcode the next code
   task t_ctrl;
      logic [4:0] base [7];
      logic [31:0] e;
      base = '{5'h05, 5'h07, 5'h09, 5'h0C, 5'h0E, 5'h10, 5'h12};
      for (int i = 0; i < 7; i++)
      begin
         set_acc(4'hA ^ i[3:0]);
         cmd(base[i] + 5'h01);
      end
      set_acc(4'h7);
      cmd(itr_pkg::OP_WR_PSC_CTRL);
      rd_chk(itr_pkg::ADDR_ACC, 32'h0000_0007);
      for (int i = 0; i < 7; i++)
      begin
         set_acc(4'h0);
         cmd(base[i]);
         e = {28'h0, 4'hA ^ i[3:0]};
         bus(1'b0, itr_pkg::ADDR_ACC, 32'h0000_0000);
         chk(rd, e);
      end
   endtask

   task t_psc;
      set_acc(4'h5);
      set_aux(4'hA);
      cmd(itr_pkg::OP_WR_PSC);
      set_acc(4'h0);
      set_aux(4'h0);
      cmd(itr_pkg::OP_RD_PSC);
      rd_chk(itr_pkg::ADDR_ACC, 32'h0000_0005);
      rd_chk(itr_pkg::ADDR_AUX, 32'h0000_000A);
   endtask

   task t_t1;
      set_acc(4'hC);
      set_aux(4'h3);
      cmd(itr_pkg::OP_WR_T1);
      set_acc(4'hE);
      set_aux(4'h9);
      cmd(itr_pkg::OP_WR_T1_HIGH);
      set_acc(4'h0);
      set_aux(4'h0);
      cmd(itr_pkg::OP_RD_T1);
      rd_chk(itr_pkg::ADDR_ACC, 32'h0000_000C);
      rd_chk(itr_pkg::ADDR_AUX, 32'h0000_0003);
   endtask

   task t_ext0;
      @(posedge hclk);
      ext0_fire <= 1'b1;
      @(posedge hclk);
      ext0_fire <= 1'b0;
      poll(itr_pkg::STAT_EXT0_REQ_BIT, 1'b1);
      set_acc(4'h1);
      cmd(itr_pkg::OP_WR_IRQ_FIRST);
      cmd(itr_pkg::OP_TEST_EXT0);
      rd_chk(itr_pkg::ADDR_STATUS, 32'h0000_0002);
      chk({29'h0, flag_s}, 32'h0000_0002);
      set_acc(4'h0);
      cmd(itr_pkg::OP_WR_IRQ_FIRST);
      cmd(itr_pkg::OP_TEST_EXT0);
      rd_chk(itr_pkg::ADDR_STATUS, 32'h0000_0004);
      chk({29'h0, flag_s}, 32'h0000_0004);
      cmd(itr_pkg::OP_IRQ_ENABLE);
      rd_chk(itr_pkg::ADDR_STATUS, 32'h0000_0000);
      chk({29'h0, flag_s}, 32'h0000_0000);
      cmd(itr_pkg::OP_TEST_EXT0);
      rd_chk(itr_pkg::ADDR_STATUS, 32'h0000_0000);
   endtask

   task t_pin;
      for (int p = 0; p < 2; p++)
      begin
         for (int l = 0; l < 2; l++)
         begin
            set_acc({1'b0, p[0], 2'b00});
            cmd(itr_pkg::OP_WR_PIN_IRQ);
            @(posedge hclk);
            int_lvl <= l[0];
            poll(itr_pkg::STAT_INT_PIN_BIT, l[0]);
            cmd(itr_pkg::OP_TEST_PIN);
            bus(1'b0, itr_pkg::ADDR_STATUS, 32'h0000_0000);
            chk({31'h0, rd[2]}, {31'h0, l[0] == p[0]});
            cmd(itr_pkg::OP_NO_OPERATION);
         end
      end
   endtask

   // mid-run reset clears flags and registers
   task t_reset;
      cmd(itr_pkg::OP_IRQ_ENABLE);
      set_acc(4'h9);
      @(posedge hclk);
      hresetn <= 1'b0;
      int_lvl <= 1'b0;
      repeat (3) @(posedge hclk);
      chk({28'h0, rdy_s, flag_s}, 32'h0000_0008);
      hresetn <= 1'b1;
      rd_chk(itr_pkg::ADDR_ACC, 32'h0000_0000);
      rd_chk(itr_pkg::ADDR_STATUS, 32'h0000_0000);
      chk({29'h0, flag_s}, 32'h0000_0000);
   endtask

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      int_lvl = 1'b0;
      ext0_fire = 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_irq;
      t_ctrl;
      t_psc;
      t_t1;
      t_ext0;
      t_pin;
      t_reset;
      results;
   end
endmodule
